// >>> der_event_regs.sv
// diagnostic event register block: condition sync, status logic, avalon slave, nvm hand-off
`timescale 1ns/100ps
module der_event_regs
    import der_pkg::*;
#(
    parameter int unsigned NUM_EVENTS = DER_NUM_EVENTS
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_in,
    input  wire der_avs_req_t          avs_req_in,
    output logic                       avs_waitrequest_out,
    output logic [31:0]                avs_readdata_out,
    output logic [1:0]                 avs_response_out,
    input  wire logic [NUM_EVENTS-1:0] event_cond_in,
    input  wire logic                  nvm_load_in,
    input  wire der_nvm_rec_t          nvm_load_rec_in,
    output logic                       nvm_store_req_out,
    output der_nvm_rec_t               nvm_store_rec_out,
    input  wire logic                  nvm_store_ack_in,
    output logic [NUM_EVENTS-1:0]      event_status_out,
    output logic [DER_CNT_W-1:0]       event_count_out,
    output logic                       irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [NUM_EVENTS-1:0] sync1;
        logic [NUM_EVENTS-1:0] sync2;
        logic [NUM_EVENTS-1:0] sync3;
        logic [NUM_EVENTS-1:0] cond;
        logic [NUM_EVENTS-1:0] sticky;
        logic [NUM_EVENTS-1:0] status;
        logic [DER_CNT_W-1:0]  count;
        logic [NUM_EVENTS-1:0] mask;
        logic [NUM_EVENTS-1:0] latch;
        logic                  ack;
        logic [31:0]           rdata;
        logic [1:0]            resp;
        logic                  armed;
        logic [DER_IRQ_W-1:0]  irq_stat;
        logic [DER_IRQ_W-1:0]  irq_mask;
        logic                  nvm_req;
        der_nvm_rec_t          nvm_rec;
    } der_state_t;

    der_state_t state_q;
    der_state_t state_d;

    logic                  bus_req;
    logic                  wr_fire;
    logic                  rd_first;
    logic                  clr_fire;
    logic [NUM_EVENTS-1:0] new_bits;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] der_merge16(input logic [15:0] old_v,
                                                input logic [31:0] wdata,
                                                input logic [3:0]  be);
        logic [15:0] r;
        r = old_v;
        if (be[0]) begin
            r[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            r[15:8] = wdata[15:8];
        end
        return r;
    endfunction

    function automatic logic [DER_CNT_W-1:0] der_popcount(input logic [NUM_EVENTS-1:0] v);
        logic [DER_CNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < NUM_EVENTS; i++) begin
            n = n + DER_CNT_W'(v[i]);
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // one wait cycle per access: request taken, data ready, then waitrequest drops
    assign bus_req  = avs_req_in.read | avs_req_in.write;
    assign rd_first = bus_req & ~state_q.ack;
    assign wr_fire  = avs_req_in.write & state_q.ack;
    assign clr_fire = wr_fire && (avs_req_in.address == DER_OFS_CMD) && avs_req_in.byteenable[0]
                      && state_q.armed && (avs_req_in.writedata[7:0] == DER_KEY_CONFIRM);
    assign new_bits = state_d.status & ~state_q.status;

    always_comb begin
        state_d = state_q;

        // three-stage sync; a change counts once stages two and three agree
        state_d.sync1 = event_cond_in;
        state_d.sync2 = state_q.sync1;
        state_d.sync3 = state_q.sync2;
        for (int i = 0; i < NUM_EVENTS; i++) begin
            if (state_q.sync2[i] == state_q.sync3[i]) begin
                state_d.cond[i] = state_q.sync3[i];
            end
        end

        // sticky only collects enabled events, so a later unmask shows nothing stale
        if (clr_fire) begin
            state_d.sticky = '0;
            state_d.status = '0;
        end else begin
            state_d.sticky = state_q.sticky | (state_q.mask & state_q.cond);
            state_d.status = state_q.mask
                           & ((state_q.latch & state_d.sticky)
                           | (~state_q.latch & state_q.cond));
        end
        state_d.count = der_popcount(state_q.status);

        // bus: read data captured on the first cycle, writes land when waitrequest is low
        state_d.ack = rd_first;
        if (rd_first) begin
            state_d.rdata = '0;
            state_d.resp  = DER_RESP_OKAY;
            unique case (avs_req_in.address)
                DER_OFS_STATUS:   state_d.rdata[NUM_EVENTS-1:0] = state_q.status;
                DER_OFS_MASK:     state_d.rdata[NUM_EVENTS-1:0] = state_q.mask;
                DER_OFS_LATCH:    state_d.rdata[NUM_EVENTS-1:0] = state_q.latch;
                DER_OFS_COUNT:    state_d.rdata[DER_CNT_W-1:0]  = state_q.count;
                DER_OFS_CMD:      state_d.rdata[0]              = state_q.armed;
                DER_OFS_IRQ_STAT: state_d.rdata[DER_IRQ_W-1:0]  = state_q.irq_stat;
                DER_OFS_IRQ_MASK: state_d.rdata[DER_IRQ_W-1:0]  = state_q.irq_mask;
                default:          state_d.resp                  = DER_RESP_DECERR;
            endcase
        end

        // restored settings from nonvolatile memory, overridden by a bus write in the same cycle
        if (nvm_load_in) begin
            state_d.mask  = nvm_load_rec_in.mask;
            state_d.latch = nvm_load_rec_in.latch;
        end

        // nvm handshake: request held until acknowledged
        if (nvm_store_ack_in) begin
            state_d.nvm_req = 1'b0;
        end

        if (wr_fire) begin
            unique case (avs_req_in.address)
                DER_OFS_MASK: begin
                    state_d.mask    = der_merge16(state_q.mask, avs_req_in.writedata,
                                                  avs_req_in.byteenable);
                    state_d.nvm_req = 1'b1;
                end
                DER_OFS_LATCH: begin
                    state_d.latch   = der_merge16(state_q.latch, avs_req_in.writedata,
                                                  avs_req_in.byteenable);
                    state_d.nvm_req = 1'b1;
                end
                DER_OFS_CMD: begin
                    // any other value or a confirm disarms, so a stray write cannot clear
                    if (avs_req_in.byteenable[0]) begin
                        state_d.armed = (avs_req_in.writedata[7:0] == DER_KEY_ARM);
                    end
                end
                DER_OFS_IRQ_MASK: begin
                    if (avs_req_in.byteenable[0]) begin
                        state_d.irq_mask = avs_req_in.writedata[DER_IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // record follows the live settings; the nvm side copies it at its ack
        state_d.nvm_rec.mask  = state_d.mask;
        state_d.nvm_rec.latch = state_d.latch;

        // sticky interrupts: write one to clear, a new event in the same cycle wins
        if (wr_fire && (avs_req_in.address == DER_OFS_IRQ_STAT) && avs_req_in.byteenable[0]) begin
            state_d.irq_stat = state_q.irq_stat & ~avs_req_in.writedata[DER_IRQ_W-1:0];
        end
        // rising bits taken from state_d here, so the process never reads back its own net
        if (|(state_d.status & ~state_q.status)) begin
            state_d.irq_stat[DER_IRQ_NEW_EVENT] = 1'b1;
        end
        if (clr_fire) begin
            state_d.irq_stat[DER_IRQ_CLEARED] = 1'b1;
        end
        if (state_q.nvm_req && nvm_store_ack_in) begin
            state_d.irq_stat[DER_IRQ_NVM_DONE] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q          <= '0;
            state_q.mask     <= DER_MASK_RST;
            state_q.latch    <= DER_LATCH_RST;
            state_q.nvm_rec  <= '{mask: DER_MASK_RST, latch: DER_LATCH_RST};
        end else begin
            state_q <= state_d;
        end
    end

    assign avs_waitrequest_out = bus_req & ~state_q.ack;
    assign avs_readdata_out    = state_q.rdata;
    assign avs_response_out    = state_q.resp;
    assign nvm_store_req_out   = state_q.nvm_req;
    assign nvm_store_rec_out   = state_q.nvm_rec;
    assign event_status_out    = state_q.status;
    assign event_count_out     = state_q.count;
    assign irq_out             = |(state_q.irq_stat & state_q.irq_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    logic mask_wr;
    logic latch_wr;
    assign mask_wr  = wr_fire && (avs_req_in.address == DER_OFS_MASK);
    assign latch_wr = wr_fire && (avs_req_in.address == DER_OFS_LATCH);

    a_mask_gates_status: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        1'b1 |=> ((state_q.status & ~$past(state_q.mask)) == '0))
        else $error("status bit set for a masked event");

    a_unlatched_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !clr_fire |=> ((state_q.status & ~$past(state_q.latch))
                       == ($past(state_q.mask) & ~$past(state_q.latch) & $past(state_q.cond))))
        else $error("unlatched status does not follow the condition");

    a_latched_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (!clr_fire && !mask_wr && !latch_wr && !nvm_load_in)
        ##1 (!clr_fire && !nvm_load_in)
        |-> ((state_q.status & $past(state_q.status & state_q.latch & state_q.mask))
             == $past(state_q.status & state_q.latch & state_q.mask)))
        else $error("latched status bit dropped without reset");

    a_clear_all_bits: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        clr_fire |=> (state_q.status == '0) && (state_q.sticky == '0)
                     && state_q.irq_stat[DER_IRQ_CLEARED])
        else $error("confirmed reset did not clear the status register");

    a_clear_needs_arm: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $rose(state_q.armed) |-> $past(wr_fire && (avs_req_in.address == DER_OFS_CMD)
                                        && (avs_req_in.writedata[7:0] == DER_KEY_ARM)))
        else $error("clear armed without an arming write");

    a_count_tracks: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        1'b1 |=> (state_q.count == DER_CNT_W'($countones($past(state_q.status)))))
        else $error("event count differs from status bits");

    a_nvm_store_req: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (mask_wr || latch_wr) |=> nvm_store_req_out
                                  && (nvm_store_rec_out.mask == state_q.mask)
                                  && (nvm_store_rec_out.latch == state_q.latch))
        else $error("accepted settings not offered to nvm");

    a_nvm_req_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (nvm_store_req_out && !nvm_store_ack_in) |=> nvm_store_req_out)
        else $error("nvm request dropped before ack");

    a_mask_write_bit: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (mask_wr && avs_req_in.byteenable[0] && !avs_req_in.byteenable[1])
        |=> (state_q.mask[15:8] == $past(state_q.mask[15:8]))
            && (state_q.mask[7:0] == $past(avs_req_in.writedata[7:0])))
        else $error("mask byte lanes not honoured");

    a_wait_bounded: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        bus_req |-> ##[0:1] !avs_waitrequest_out)
        else $error("waitrequest held too long");

    a_irq_new_event: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (|new_bits) |=> state_q.irq_stat[DER_IRQ_NEW_EVENT])
        else $error("new event did not set its interrupt bit");

    // reset is asynchronous, so two sampled reset edges are needed before state is known
    a_reset_defaults: assert property (@(posedge sys_clk_in)
        rst_in ##1 rst_in |-> (state_q.status == '0) && (state_q.mask == DER_MASK_RST)
                              && (state_q.latch == DER_LATCH_RST))
        else $error("reset did not clear status and restore defaults");

    a_read_status: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rd_first && avs_req_in.read && (avs_req_in.address == DER_OFS_STATUS))
        |=> (avs_readdata_out == 32'($past(state_q.status))))
        else $error("status read does not return the status bits");

    c_latched_event:  cover property (@(posedge sys_clk_in) disable iff (rst_in)
        (state_q.latch != '0) && (state_q.status & state_q.latch & ~state_q.cond) != '0);
    c_confirmed_clr:  cover property (@(posedge sys_clk_in) disable iff (rst_in) clr_fire);
    c_nvm_handshake:  cover property (@(posedge sys_clk_in) disable iff (rst_in)
        nvm_store_req_out && nvm_store_ack_in);
    c_unmapped_read:  cover property (@(posedge sys_clk_in) disable iff (rst_in)
        !avs_waitrequest_out && avs_req_in.read && (avs_response_out == DER_RESP_DECERR));
    c_byte_lane_wr:   cover property (@(posedge sys_clk_in) disable iff (rst_in)
        mask_wr && !avs_req_in.byteenable[1]);

endmodule

// >>> der_event_regs_tb.sv
// self-checking testbench of the diagnostic event register block
`timescale 1ns/100ps
module der_event_regs_tb;
    import der_pkg::*;
    logic         sys_clk_in, rst_in, avs_waitrequest_out, nvm_load_in, nvm_store_req_out, nvm_store_ack_in;
    logic         irq_out, load_go;
    der_avs_req_t avs_req;
    logic [31:0]  avs_readdata_out, seed, c, m;
    logic [1:0]   avs_response_out;
    logic [15:0]  event_cond_in, event_status_out;
    logic [4:0]   event_count_out;
    der_nvm_rec_t nvm_load_rec_in, nvm_store_rec_out, saved_rec, load_rec;
    logic [33:0]  exp_q[$];
    logic [33:0]  note;
    int           err_count, n_tests;
    ////////////////////////////////////////////////////////////////////////////////
    der_event_regs uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_req_in(avs_req),
        .avs_waitrequest_out(avs_waitrequest_out), .avs_readdata_out(avs_readdata_out),
        .avs_response_out(avs_response_out), .event_cond_in(event_cond_in), .nvm_load_in(nvm_load_in),
        .nvm_load_rec_in(nvm_load_rec_in), .nvm_store_req_out(nvm_store_req_out),
        .nvm_store_rec_out(nvm_store_rec_out), .nvm_store_ack_in(nvm_store_ack_in),
        .event_status_out(event_status_out), .event_count_out(event_count_out), .irq_out(irq_out));
    der_nvm_model nvm (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .store_req_in(nvm_store_req_out),
        .store_rec_in(nvm_store_rec_out), .store_ack_out(nvm_store_ack_in), .saved_rec_out(saved_rec),
        .load_go_in(load_go), .load_rec_in(load_rec), .load_out(nvm_load_in), .load_rec_out(nvm_load_rec_in));
    always #10 sys_clk_in = ~sys_clk_in;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] pc(input logic [15:0] v);
        int n;
        n = 0;
        for (int i = 0; i < 16; i++) n += v[i];
        return 32'(n);
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] wd);
        int k;
        @(posedge sys_clk_in);
        avs_req.read <= rd;
        avs_req.write <= ~rd;
        avs_req.address <= a;
        avs_req.writedata <= wd;
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk_in);
            if (avs_waitrequest_out === 1'b0) break;
        end
        if (k == 20) begin
            err_count++;
            tally_and_finish();
        end
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] r = DER_RESP_OKAY);
        exp_q.push_back({r, e});
        bus(1'b1, a, 32'h0);
    endtask
    // conditions pass sync and filter, then status and count: eight edges cover it
    task automatic cond(input logic [15:0] v);
        @(posedge sys_clk_in);
        event_cond_in <= v;
        repeat (8) @(posedge sys_clk_in);
    endtask
    task automatic nvm_wait(input logic [15:0] em, input logic [15:0] el);
        int k;
        repeat (2) @(posedge sys_clk_in);
        for (k = 0; k < 20 && nvm_store_req_out !== 1'b0; k++) @(posedge sys_clk_in);
        if (k == 20) begin
            err_count++;
            tally_and_finish();
        end
        check("saved", {saved_rec.mask, saved_rec.latch}, {em, el});
    endtask
    task automatic clear_status();
        wr(DER_OFS_CMD, {24'h0, DER_KEY_ARM});
        wr(DER_OFS_CMD, {24'h0, DER_KEY_CONFIRM});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_in) begin
        if (avs_req.read === 1'b1 && avs_waitrequest_out === 1'b0) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("[FAIL] readdata expected a note seen none");
            end else begin
                note = exp_q.pop_front();
                check("readdata", avs_readdata_out, note[31:0]);
                check("response", {30'h0, avs_response_out}, {30'h0, note[33:32]});
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_in = 1'b0;
        rst_in = 1'b1;
        avs_req = '0;
        avs_req.byteenable = 4'hf;
        event_cond_in = '0;
        load_go = 1'b0;
        load_rec = '0;
        seed = 32'd99241;
        err_count = 0;
        n_tests = 0;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rd(DER_OFS_MASK, 32'h1);
        rd(DER_OFS_LATCH, 32'h0);
        rd(DER_OFS_STATUS, 32'h0);
        rd(5'h1c, 32'h0, DER_RESP_DECERR);
        cond(16'hffff);
        rd(DER_OFS_STATUS, 32'h1);
        wr(DER_OFS_MASK, 32'hffff);
        nvm_wait(16'hffff, 16'h0);
        // one condition at a time lands on its own bit
        for (int i = 0; i < 16; i++) begin
            cond(16'h1 << i);
            check("status_pin", {16'h0, event_status_out}, 32'h1 << i);
            check("count_pin", {27'h0, event_count_out}, 32'h1);
            rd(DER_OFS_STATUS, 32'h1 << i);
            rd(DER_OFS_COUNT, 32'h1);
        end
        wr(DER_OFS_STATUS, 32'h1234);
        rd(DER_OFS_STATUS, 32'h8000);
        for (int j = 0; j < 4; j++) begin
            m = xs() & 32'hffff;
            c = xs();
            wr(DER_OFS_MASK, m);
            nvm_wait(m[15:0], 16'h0);
            cond(c[15:0]);
            rd(DER_OFS_STATUS, m & c & 32'hffff);
            rd(DER_OFS_COUNT, pc(m[15:0] & c[15:0]));
        end
        // low byte lane only: the upper mask bits must keep their value
        avs_req.byteenable <= 4'h1;
        wr(DER_OFS_MASK, 32'h5a3c);
        avs_req.byteenable <= 4'hf;
        rd(DER_OFS_MASK, {16'h0, m[15:8], 8'h3c});
        nvm_wait({m[15:8], 8'h3c}, 16'h0);
        wr(DER_OFS_MASK, 32'hffff);
        nvm_wait(16'hffff, 16'h0);
        wr(DER_OFS_LATCH, 32'h0f0f);
        nvm_wait(16'hffff, 16'h0f0f);
        cond(16'h0);
        clear_status();
        rd(DER_OFS_STATUS, 32'h0);
        c = xs() | 32'h0101;
        cond(c[15:0]);
        cond(16'h0);
        rd(DER_OFS_STATUS, c & 32'h0f0f);
        // a confirm without arming must leave latched bits alone
        wr(DER_OFS_CMD, {24'h0, DER_KEY_CONFIRM});
        rd(DER_OFS_STATUS, c & 32'h0f0f);
        clear_status();
        rd(DER_OFS_STATUS, 32'h0);
        wr(DER_OFS_IRQ_MASK, 32'h1);
        wr(DER_OFS_IRQ_STAT, 32'h7);
        cond(16'h0010);
        check("irq_set", {31'h0, irq_out}, 32'h1);
        wr(DER_OFS_IRQ_STAT, 32'h1);
        repeat (3) @(posedge sys_clk_in);
        check("irq_clr", {31'h0, irq_out}, 32'h0);
        wr(DER_OFS_IRQ_MASK, 32'h0);
        cond(16'h0030);
        check("irq_masked", {31'h0, irq_out}, 32'h0);
        rd(DER_OFS_IRQ_STAT, 32'h1);
        @(posedge sys_clk_in);
        load_rec <= '{mask: 16'h00f0, latch: 16'h0003};
        load_go <= 1'b1;
        @(posedge sys_clk_in);
        load_go <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        rd(DER_OFS_MASK, 32'h00f0);
        rd(DER_OFS_LATCH, 32'h0003);
        // second reset mid-run drops status and restores defaults
        cond(16'hfffe);
        rd(DER_OFS_STATUS, 32'h00f0);
        rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rd(DER_OFS_STATUS, 32'h0);
        rd(DER_OFS_MASK, 32'h1);
        rd(DER_OFS_LATCH, 32'h0);
        repeat (2) @(posedge sys_clk_in);
        tally_and_finish();
    end
endmodule

// >>> der_nvm_model.sv
// far-side model: nonvolatile store that saves settings and replays the record given on load_rec_in
`timescale 1ns/100ps
module der_nvm_model
    import der_pkg::*;
(
    input  wire logic         sys_clk_in,
    input  wire logic         rst_in,
    input  wire logic         store_req_in,
    input  wire der_nvm_rec_t store_rec_in,
    output logic              store_ack_out,
    output der_nvm_rec_t      saved_rec_out,
    input  wire logic         load_go_in,
    input  wire der_nvm_rec_t load_rec_in,
    output logic              load_out,
    output der_nvm_rec_t      load_rec_out
);
    logic [1:0] wait_q;
    logic       slow_q;
    ////////////////////////////////////////////////////////////////////////////////
    // alternates prompt and slow saves so both ack timings are seen
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_q <= '0;
            slow_q <= 1'b0;
            store_ack_out <= 1'b0;
            saved_rec_out <= '0;
            load_out <= 1'b0;
            load_rec_out <= '0;
        end else begin
            load_out <= load_go_in;
            // record lines carry junk outside a load pulse
            load_rec_out <= load_go_in ? load_rec_in : ~load_rec_out;
            if (store_req_in && !store_ack_out) begin
                if (wait_q == (slow_q ? 2'h3 : 2'h0)) begin
                    store_ack_out <= 1'b1;
                    saved_rec_out <= store_rec_in;
                    slow_q <= ~slow_q;
                    wait_q <= '0;
                end else begin
                    wait_q <= wait_q + 2'h1;
                end
            end else begin
                store_ack_out <= 1'b0;
                wait_q <= '0;
            end
        end
    end
endmodule

// >>> der_pkg.sv
// constants, types and bus carriers of the diagnostic event register block
package der_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int unsigned DER_NUM_EVENTS = 16;
    localparam int unsigned DER_CNT_W      = 5;
    localparam int unsigned DER_ADDR_W     = 5;
    localparam int unsigned DER_IRQ_W      = 3;

    // event bit positions
    localparam int unsigned DER_EV_CPU_OVER_TEMP     = 0;
    localparam int unsigned DER_EV_DIFF_SENSOR_INIT  = 1;
    localparam int unsigned DER_EV_ABS_SENSOR_INIT   = 2;
    localparam int unsigned DER_EV_VREF_RANGE        = 3;
    localparam int unsigned DER_EV_FLOW_RANGE        = 4;
    localparam int unsigned DER_EV_ABS_OVER_RANGE    = 5;
    localparam int unsigned DER_EV_GAS_TEMP_RANGE    = 6;
    localparam int unsigned DER_EV_ANALOG_OUT_ALARM  = 7;
    localparam int unsigned DER_EV_SERIAL_COMM       = 8;
    localparam int unsigned DER_EV_FIELDBUS_COMM     = 9;
    localparam int unsigned DER_EV_NVM_RW            = 10;
    localparam int unsigned DER_EV_AUTO_ZERO_FAIL    = 11;
    localparam int unsigned DER_EV_ABS_TARE_FAIL     = 12;
    localparam int unsigned DER_EV_DIFF_COUNTS_BAD   = 13;
    localparam int unsigned DER_EV_ABS_COUNTS_BAD    = 14;
    localparam int unsigned DER_EV_FATAL             = 15;

    // register byte offsets
    localparam logic [DER_ADDR_W-1:0] DER_OFS_STATUS    = 5'h00;
    localparam logic [DER_ADDR_W-1:0] DER_OFS_MASK      = 5'h04;
    localparam logic [DER_ADDR_W-1:0] DER_OFS_LATCH     = 5'h08;
    localparam logic [DER_ADDR_W-1:0] DER_OFS_COUNT     = 5'h0c;
    localparam logic [DER_ADDR_W-1:0] DER_OFS_CMD       = 5'h10;
    localparam logic [DER_ADDR_W-1:0] DER_OFS_IRQ_STAT  = 5'h14;
    localparam logic [DER_ADDR_W-1:0] DER_OFS_IRQ_MASK  = 5'h18;

    // reset values
    localparam logic [15:0] DER_MASK_RST  = 16'h0001;
    localparam logic [15:0] DER_LATCH_RST = 16'h0000;

    // command keys: arm first, then confirm
    localparam logic [7:0] DER_KEY_ARM     = 8'h5a;
    localparam logic [7:0] DER_KEY_CONFIRM = 8'ha5;

    // interrupt status bits
    localparam int unsigned DER_IRQ_NEW_EVENT = 0;
    localparam int unsigned DER_IRQ_CLEARED   = 1;
    localparam int unsigned DER_IRQ_NVM_DONE  = 2;

    // avalon responses
    localparam logic [1:0] DER_RESP_OKAY   = 2'h0;
    localparam logic [1:0] DER_RESP_DECERR = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic                  read;
        logic                  write;
        logic [DER_ADDR_W-1:0] address;
        logic [31:0]           writedata;
        logic [3:0]            byteenable;
    } der_avs_req_t;

    typedef struct packed {
        logic [15:0] mask;
        logic [15:0] latch;
    } der_nvm_rec_t;

endpackage
